/* File: rtl/sbc_ctrl_pkg.sv */
`default_nettype none

package sbc_ctrl_pkg;

    // ----------------------------------------------------------------
    // Register addresses (7-bit frame address)
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_WAKE_BIAS = 7'h08;
    localparam logic [6:0] ADDR_XCVR_PAIR = 7'h0a;
    localparam logic [6:0] ADDR_WAKE_PERIOD = 7'h0c;
    localparam logic [6:0] ADDR_HW_CONFIG = 7'h0e;

    // ----------------------------------------------------------------
    // Writable bit masks, reset values, field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_WAKE_BIAS = 8'h03;
    localparam logic [7:0] MASK_XCVR_PAIR = 8'hdb;
    localparam logic [7:0] MASK_WAKE_PERIOD = 8'h07;
    localparam logic [7:0] MASK_HW_CONFIG = 8'hef;
    localparam logic [7:0] MASK_HW_RESTART_KEEP = 8'h4f;
    localparam logic [7:0] MASK_HW_SOFT_KEEP = 8'h03;
    localparam logic [7:0] RST_WAKE_BIAS = 8'h00;
    localparam logic [7:0] RST_XCVR_PAIR = 8'h00;
    localparam logic [7:0] RST_WAKE_PERIOD = 8'h00;
    localparam logic [7:0] RST_HW_CONFIG = 8'h01;
    localparam logic [7:0] RST_READ_BYTE = 8'h00;
    localparam int POS_TWO_HIGH_SPEED = 7;
    localparam int POS_ONE_HIGH_SPEED = 6;
    localparam int POS_TWO_MODE = 3;
    localparam int POS_ONE_MODE = 0;
    localparam int POS_ADC_SEL = 7;
    localparam int POS_SOFT_RST_OUT_DIS = 6;
    localparam int POS_BOOST_AUTO_OFF = 5;
    localparam int POS_BOOST_V = 2;
    localparam int POS_EXT_V = 0;
    localparam logic [1:0] EXT_V_FORCED = 2'b01;
    localparam logic [2:0] PERIOD_RESERVED = 3'b111;

    // ----------------------------------------------------------------
    // Frame and timing
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam logic [3:0] BIT_LAST = 4'hf;
    localparam logic [3:0] BIT_LOAD_DATA = 4'h7;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int RST_PULSE_NS = 10000;
    localparam int RST_PULSE_CYCLES =
        (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RST_CNT_W = 12;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BIAS_NONE = 2'b00,
        BIAS_PULL_DOWN = 2'b01,
        BIAS_PULL_UP = 2'b10,
        BIAS_AUTO = 2'b11
    } wake_bias_t;

    typedef enum logic [1:0] {
        XCVR_OFF = 2'b00,
        XCVR_WAKE_CAPABLE = 2'b01,
        XCVR_RECEIVE_ONLY = 2'b10,
        XCVR_NORMAL = 2'b11
    } xcvr_mode_t;

    typedef enum logic {
        AUTO_DOWN = 1'b0,
        AUTO_UP = 1'b1
    } auto_bias_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic write;
        logic [6:0] addr;
    } spi_frame_t;

    typedef struct packed {
        logic wake_pull_up;
        logic wake_pull_down;
        xcvr_mode_t transceiver_two_mode;
        xcvr_mode_t transceiver_one_mode;
        logic transceiver_two_high_speed;
        logic transceiver_one_high_speed;
        logic [2:0] cyclic_wake_period_select;
        logic cyclic_period_valid;
        logic [10:0] cyclic_period_ms;
        logic adc_sel_battery_sense;
        logic boost_auto_shutoff_enable;
        logic boost_off;
        logic [1:0] boost_voltage_select;
        logic [1:0] external_supply_voltage_select;
    } ctrl_out_t;

endpackage : sbc_ctrl_pkg

`default_nettype wire

/* File: rtl/sbc_ctrl_regs.sv */
// Overview of operation
// - Wake bias code 00 none, 01 pull-down, 10 pull-up.
// - Wake bias code 11 switches pull-up and pull-down automatically.
// - Reserved bits read zero and ignore writes.
// - Wake bias clears on power-on and soft reset; restart keeps low bits.
// - Transceiver modes off, wake, receive-only, normal; bits 4:3, 1:0.
// - High-speed bits 7 and 6 remove slew control above 5MBaud.
// - Fail-safe entry rewrites bus settings so device stays wakeable.
// - Cyclic wake codes 000..110 select 10ms up to 2s.
// - Cyclic wake register clears on power-on, soft reset and restart.
// - Bit 7 routes converter input to wake pin or battery sense.
// - Bit 6 clear pulls reset output low during software reset.
// - Bit 5 set switches boost off on battery-sense low voltage.
// - Boost voltage bits 3:2 select 6.7V, 8V, 10V, 12V.
// - Supply voltage bits 1:0 select 5.0V, 3.3V, 1.8V, 1.2V.
// - Software reset keeps supply field; power-on loads its default.
// - Power-config pin at ground blocks supply writes, reads 01.
`default_nettype none

module sbc_ctrl_regs
    import sbc_ctrl_pkg::*;
(
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Serial link
    input wire logic i_spi_sck,
    input wire logic i_spi_csn_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    // Device events, same clock
    input wire logic i_soft_reset,
    input wire logic i_restart,
    input wire logic i_fail_safe_entry,
    // Pins and analog status
    input wire logic i_power_config_pin,
    input wire logic i_wake_input_pin,
    input wire logic i_battery_sense_low,
    // Control outputs
    output ctrl_out_t o_ctrl,
    output logic o_reset_output_pin_n
);

    // ----------------------------------------------------------------
    // Link domain: frame shifter
    // ----------------------------------------------------------------
    logic [3:0] bit_cnt_r;
    logic [FRAME_BITS-1:0] shift_r;
    spi_frame_t frame_r;
    logic frame_tog_r;
    logic [7:0] tx_shift_r;
    logic resp_sync1_r;
    logic resp_sync2_r;
    logic resp_seen_r;
    logic [7:0] resp_hold_r;
    logic miso_r;

    // Resp toggle and byte from system domain
    logic resp_tog_r;
    logic [7:0] resp_byte_r;

    // Bit counter restarts whenever chip select is released
    always_ff @(posedge i_spi_sck or posedge i_spi_csn_n
        or negedge i_resetn) begin
        if (!i_resetn || i_spi_csn_n) begin
            bit_cnt_r <= 4'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // First bit on the wire is bit 0 of the frame
    always_ff @(posedge i_spi_sck or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_r <= '0;
        end else if (!i_spi_csn_n) begin
            shift_r <= {i_spi_mosi, shift_r[FRAME_BITS-1:1]};
        end
    end

    // Whole frame captured on its last bit
    always_ff @(posedge i_spi_sck or negedge i_resetn) begin
        if (!i_resetn) begin
            frame_r <= '0;
            frame_tog_r <= 1'b0;
        end else if (!i_spi_csn_n && bit_cnt_r == BIT_LAST) begin
            frame_r <= spi_frame_t'({i_spi_mosi, shift_r[FRAME_BITS-1:1]});
            frame_tog_r <= ~frame_tog_r;
        end
    end

    // Response byte crossing into link domain
    always_ff @(posedge i_spi_sck or negedge i_resetn) begin
        if (!i_resetn) begin
            resp_sync1_r <= 1'b0;
            resp_sync2_r <= 1'b0;
            resp_seen_r <= 1'b0;
            resp_hold_r <= RST_READ_BYTE;
        end else begin
            resp_sync1_r <= resp_tog_r;
            resp_sync2_r <= resp_sync1_r;
            if (resp_sync2_r != resp_seen_r) begin
                resp_seen_r <= resp_sync2_r;
                resp_hold_r <= resp_byte_r;
            end
        end
    end

    // Data byte shifted out during bits 8..15, lsb first
    always_ff @(posedge i_spi_sck or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_shift_r <= '0;
        end else if (!i_spi_csn_n) begin
            if (bit_cnt_r == BIT_LOAD_DATA) begin
                tx_shift_r <= resp_hold_r;
            end else begin
                tx_shift_r <= {1'b0, tx_shift_r[7:1]};
            end
        end
    end

    // Output changes on falling edge, host samples on rising
    always_ff @(negedge i_spi_sck or negedge i_resetn) begin
        if (!i_resetn) begin
            miso_r <= 1'b0;
        end else begin
            miso_r <= tx_shift_r[0];
        end
    end

    assign o_spi_miso = miso_r;

    // ----------------------------------------------------------------
    // System domain: synchronisers
    // ----------------------------------------------------------------
    logic [1:0] frame_sync_r;
    logic frame_seen_r;
    logic [1:0] csn_sync_r;
    logic [1:0] power_config_pin_sync_r;
    logic [1:0] wake_sync_r;
    logic [1:0] vbat_low_sync_r;
    logic miso_oe_r;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            frame_sync_r <= 2'b00;
            csn_sync_r <= 2'b11;
            power_config_pin_sync_r <= 2'b11;
            wake_sync_r <= 2'b00;
            vbat_low_sync_r <= 2'b00;
        end else if (i_ce) begin
            frame_sync_r <= {frame_sync_r[0], frame_tog_r};
            csn_sync_r <= {csn_sync_r[0], i_spi_csn_n};
            power_config_pin_sync_r <= {power_config_pin_sync_r[0], i_power_config_pin};
            wake_sync_r <= {wake_sync_r[0], i_wake_input_pin};
            vbat_low_sync_r <= {vbat_low_sync_r[0], i_battery_sense_low};
        end
    end

    logic frame_done;
    logic power_config_pin_grounded;
    assign frame_done = frame_sync_r[1] != frame_seen_r;
    assign power_config_pin_grounded = ~power_config_pin_sync_r[1];

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            frame_seen_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end else if (i_ce) begin
            frame_seen_r <= frame_sync_r[1];
            miso_oe_r <= ~csn_sync_r[1];
        end
    end

    assign o_spi_miso_oe = miso_oe_r;

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    logic [7:0] wake_bias_r;
    logic [7:0] xcvr_pair_r;
    logic [7:0] wake_period_r;
    logic [7:0] hw_config_r;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] hw_wr_mask;

    assign wr_en = frame_done && frame_r.write;
    assign wr_data = frame_r.data;
    // Supply field frozen while config pin is grounded
    assign hw_wr_mask = power_config_pin_grounded ?
        (MASK_HW_CONFIG & ~MASK_HW_SOFT_KEEP) : MASK_HW_CONFIG;

    // Soft reset clears, restart keeps low bits
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_bias_r <= RST_WAKE_BIAS;
        end else if (i_ce) begin
            if (i_soft_reset) begin
                wake_bias_r <= RST_WAKE_BIAS;
            end else if (i_restart) begin
                wake_bias_r <= wake_bias_r & MASK_WAKE_BIAS;
            end else if (wr_en && frame_r.addr == ADDR_WAKE_BIAS) begin
                wake_bias_r <= wr_data & MASK_WAKE_BIAS;
            end
        end
    end

    // Transceivers forced wake-capable on fail-safe entry
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            xcvr_pair_r <= RST_XCVR_PAIR;
        end else if (i_ce) begin
            if (i_soft_reset) begin
                xcvr_pair_r <= RST_XCVR_PAIR;
            end else if (i_fail_safe_entry) begin
                xcvr_pair_r[POS_TWO_MODE+:2] <= XCVR_WAKE_CAPABLE;
                xcvr_pair_r[POS_ONE_MODE+:2] <= XCVR_WAKE_CAPABLE;
            end else if (wr_en && frame_r.addr == ADDR_XCVR_PAIR) begin
                xcvr_pair_r <= wr_data & MASK_XCVR_PAIR;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_period_r <= RST_WAKE_PERIOD;
        end else if (i_ce) begin
            if (i_soft_reset || i_restart) begin
                wake_period_r <= RST_WAKE_PERIOD;
            end else if (wr_en && frame_r.addr == ADDR_WAKE_PERIOD) begin
                wake_period_r <= wr_data & MASK_WAKE_PERIOD;
            end
        end
    end

    // Supply field kept through soft reset, defaulted on power-on
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            hw_config_r <= RST_HW_CONFIG;
        end else if (i_ce) begin
            if (i_soft_reset) begin
                hw_config_r <= hw_config_r & MASK_HW_SOFT_KEEP;
            end else if (i_restart) begin
                hw_config_r <= hw_config_r & MASK_HW_RESTART_KEEP;
            end else if (wr_en && frame_r.addr == ADDR_HW_CONFIG) begin
                hw_config_r <= (wr_data & hw_wr_mask)
                    | (hw_config_r & ~hw_wr_mask);
            end
        end
    end

    logic [1:0] ext_v_eff;
    assign ext_v_eff = power_config_pin_grounded ?
        EXT_V_FORCED : hw_config_r[POS_EXT_V+:2];

    // ----------------------------------------------------------------
    // Read-back of the addressed register for the next frame
    // ----------------------------------------------------------------
    logic [7:0] read_mux;

    always_comb begin
        read_mux = RST_READ_BYTE;
        unique case (frame_r.addr)
            ADDR_WAKE_BIAS: read_mux = wake_bias_r;
            ADDR_XCVR_PAIR: read_mux = xcvr_pair_r;
            ADDR_WAKE_PERIOD: read_mux = wake_period_r;
            ADDR_HW_CONFIG: read_mux = {hw_config_r[7:2], ext_v_eff};
            default: read_mux = RST_READ_BYTE;
        endcase
    end

    // Sampled one cycle after apply so writes read back updated
    logic resp_pending_r;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            resp_pending_r <= 1'b0;
            resp_byte_r <= RST_READ_BYTE;
            resp_tog_r <= 1'b0;
        end else if (i_ce) begin
            resp_pending_r <= frame_done;
            if (resp_pending_r) begin
                resp_byte_r <= read_mux;
                resp_tog_r <= ~resp_tog_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Wake bias drive, automatic mode follows the pin level
    // ----------------------------------------------------------------
    auto_bias_state_t auto_state_r;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            auto_state_r <= AUTO_DOWN;
        end else if (i_ce) begin
            unique case (auto_state_r)
                AUTO_DOWN: begin
                    if (wake_sync_r[1]) begin
                        auto_state_r <= AUTO_UP;
                    end
                end
                AUTO_UP: begin
                    if (!wake_sync_r[1]) begin
                        auto_state_r <= AUTO_DOWN;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Reset output pulse on software reset
    // ----------------------------------------------------------------
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic rst_out_n_r;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_cnt_r <= '0;
            rst_out_n_r <= 1'b1;
        end else if (i_ce) begin
            if (i_soft_reset && !hw_config_r[POS_SOFT_RST_OUT_DIS]) begin
                rst_cnt_r <= RST_CNT_W'(RST_PULSE_CYCLES);
                rst_out_n_r <= 1'b0;
            end else if (rst_cnt_r != '0) begin
                rst_cnt_r <= rst_cnt_r - 1'b1;
                rst_out_n_r <= (rst_cnt_r == RST_CNT_W'(1));
            end
        end
    end

    assign o_reset_output_pin_n = rst_out_n_r;

    // ----------------------------------------------------------------
    // Decoded control outputs
    // ----------------------------------------------------------------
    function automatic logic [10:0] period_ms(input logic [2:0] code);
        unique case (code)
            3'h0: period_ms = 11'd10;
            3'h1: period_ms = 11'd20;
            3'h2: period_ms = 11'd50;
            3'h3: period_ms = 11'd100;
            3'h4: period_ms = 11'd200;
            3'h5: period_ms = 11'd1000;
            3'h6: period_ms = 11'd2000;
            default: period_ms = 11'd0;
        endcase
    endfunction : period_ms

    ctrl_out_t ctrl_nxt;
    ctrl_out_t ctrl_r;
    wake_bias_t bias_sel;

    always_comb begin
        bias_sel = wake_bias_t'(wake_bias_r[1:0]);
        ctrl_nxt = '0;
        unique case (bias_sel)
            BIAS_NONE: ctrl_nxt.wake_pull_up = 1'b0;
            BIAS_PULL_DOWN: ctrl_nxt.wake_pull_down = 1'b1;
            BIAS_PULL_UP: ctrl_nxt.wake_pull_up = 1'b1;
            BIAS_AUTO: begin
                ctrl_nxt.wake_pull_up = auto_state_r == AUTO_UP;
                ctrl_nxt.wake_pull_down = auto_state_r == AUTO_DOWN;
            end
        endcase
        ctrl_nxt.transceiver_two_mode =
            xcvr_mode_t'(xcvr_pair_r[POS_TWO_MODE+:2]);
        ctrl_nxt.transceiver_one_mode =
            xcvr_mode_t'(xcvr_pair_r[POS_ONE_MODE+:2]);
        ctrl_nxt.transceiver_two_high_speed =
            xcvr_pair_r[POS_TWO_HIGH_SPEED];
        ctrl_nxt.transceiver_one_high_speed =
            xcvr_pair_r[POS_ONE_HIGH_SPEED];
        ctrl_nxt.cyclic_wake_period_select = wake_period_r[2:0];
        ctrl_nxt.cyclic_period_valid =
            wake_period_r[2:0] != PERIOD_RESERVED;
        ctrl_nxt.cyclic_period_ms = period_ms(wake_period_r[2:0]);
        ctrl_nxt.adc_sel_battery_sense = hw_config_r[POS_ADC_SEL];
        ctrl_nxt.boost_auto_shutoff_enable = hw_config_r[POS_BOOST_AUTO_OFF];
        ctrl_nxt.boost_off = hw_config_r[POS_BOOST_AUTO_OFF]
            & vbat_low_sync_r[1];
        ctrl_nxt.boost_voltage_select =
            hw_config_r[POS_BOOST_V+:2];
        ctrl_nxt.external_supply_voltage_select = ext_v_eff;
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_r <= '0;
        end else if (i_ce) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign o_ctrl = ctrl_r;

endmodule : sbc_ctrl_regs

`default_nettype wire

/* File: tb/sbc_ctrl_regs_monitor.sv */
`default_nettype none

module sbc_ctrl_regs_monitor
    import sbc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Watched ports
    input wire logic i_spi_csn_n,
    input wire logic o_spi_miso_oe,
    input wire logic i_soft_reset,
    input wire logic i_restart,
    input wire logic i_fail_safe_entry,
    input wire logic i_power_config_pin,
    input wire logic i_battery_sense_low,
    input wire ctrl_out_t o_ctrl,
    input wire logic o_reset_output_pin_n
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [10:0] MS_OF [8] = '{11'h00a, 11'h014, 11'h032,
        11'h064, 11'h0c8, 11'h3e8, 11'h7d0, 11'h000};
    logic [1:0] live_r;
    logic [3:0] sr_hist_r;
    logic [RST_CNT_W-1:0] low_cnt_r;

    // ----
    // Helper state
    // ----
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            live_r <= 2'h0;
        end else if (live_r != 2'h3) begin
            live_r <= live_r + 2'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sr_hist_r <= 4'h0;
        end else begin
            sr_hist_r <= {sr_hist_r[2:0], i_soft_reset};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn || o_reset_output_pin_n) begin
            low_cnt_r <= '0;
        end else begin
            low_cnt_r <= low_cnt_r + 12'h001;
        end
    end

    // ----
    // Assertions
    // ----
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence low_held_s;
        (i_battery_sense_low && o_ctrl.boost_auto_shutoff_enable) [*6];
    endsequence
    sequence soft_done_s;
        ##2 (o_ctrl.cyclic_wake_period_select == 3'h0 && !o_ctrl.wake_pull_up
            && !o_ctrl.wake_pull_down && o_ctrl.transceiver_one_mode == XCVR_OFF
            && !o_ctrl.adc_sel_battery_sense && o_ctrl.boost_voltage_select == 2'h0);
    endsequence

    bias_exclusive_a: assert property (live_r == 2'h3 |->
        !(o_ctrl.wake_pull_up && o_ctrl.wake_pull_down)) else $error("dual bias");
    period_map_a: assert property (live_r == 2'h3 |->
        o_ctrl.cyclic_period_ms == MS_OF[o_ctrl.cyclic_wake_period_select]
        && o_ctrl.cyclic_period_valid == (o_ctrl.cyclic_wake_period_select != 3'h7))
        else $error("period decode wrong");
    boost_gate_a: assert property (o_ctrl.boost_off
        |-> o_ctrl.boost_auto_shutoff_enable) else $error("boost off ungated");
    boost_cut_a: assert property (low_held_s |-> o_ctrl.boost_off)
        else $error("boost not cut");
    ext_forced_a: assert property ((!i_power_config_pin) [*5] |->
        o_ctrl.external_supply_voltage_select == EXT_V_FORCED)
        else $error("supply not forced");
    pulse_len_a: assert property ($rose(o_reset_output_pin_n) |->
        low_cnt_r == 12'(RST_PULSE_CYCLES)) else $error("reset pulse length");
    pulse_cause_a: assert property ($fell(o_reset_output_pin_n) |->
        sr_hist_r != 4'h0) else $error("reset pulse uncaused");
    soft_clear_a: assert property (i_soft_reset |-> soft_done_s)
        else $error("soft reset not cleared");
    soft_keep_ext_a: assert property (i_soft_reset |-> ##2
        $stable(o_ctrl.external_supply_voltage_select)) else $error("supply lost");
    restart_clear_a: assert property (i_restart && !i_soft_reset |->
        ##2 o_ctrl.cyclic_wake_period_select == 3'h0) else $error("period kept");
    fail_wake_a: assert property (i_fail_safe_entry && !i_soft_reset &&
        !i_restart |-> ##2 (o_ctrl.transceiver_two_mode == XCVR_WAKE_CAPABLE &&
        o_ctrl.transceiver_one_mode == XCVR_WAKE_CAPABLE)) else $error("no wake");
    link_drive_a: assert property ((!i_spi_csn_n) [*5] |-> o_spi_miso_oe)
        else $error("miso not driven");
endmodule : sbc_ctrl_regs_monitor

bind sbc_ctrl_regs sbc_ctrl_regs_monitor mon (.i_clk_sys, .i_resetn,
    .i_spi_csn_n, .o_spi_miso_oe, .i_soft_reset, .i_restart, .i_fail_safe_entry,
    .i_power_config_pin, .i_battery_sense_low, .o_ctrl, .o_reset_output_pin_n);

`default_nettype wire

/* File: tb/sbc_wake_bus_hw_control_regs_bench.sv */
`default_nettype none

module sbc_wake_bus_hw_control_regs_bench import sbc_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, resetn, ce, sck, csn_n, mosi, miso, miso_oe, miso_w;
    logic soft_rst, restart, fail_safe, power_config_pin, wake_pin, batt_low, rst_pin_n;
    ctrl_out_t ctrl;
    logic [15:0] rx;
    int n_errors = 0;
    int n_tests = 0;

    sbc_ctrl_regs uut (.i_clk_sys(clk_sys), .i_resetn(resetn), .i_ce(ce),
        .i_spi_sck(sck), .i_spi_csn_n(csn_n), .i_spi_mosi(mosi),
        .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_soft_reset(soft_rst),
        .i_restart(restart), .i_fail_safe_entry(fail_safe),
        .i_power_config_pin(power_config_pin), .i_wake_input_pin(wake_pin),
        .i_battery_sense_low(batt_low), .o_ctrl(ctrl),
        .o_reset_output_pin_n(rst_pin_n));
    spi_host_model host (.o_sck(sck), .o_csn_n(csn_n), .o_mosi(mosi),
        .i_miso(miso_w));
    assign miso_w = miso_oe ? miso : ~miso;

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({d, 1'b1, a}, rx);
        repeat (8) @(negedge clk_sys);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.xfer({8'h00, 1'b0, a}, rx);
        host.xfer({8'h00, 1'b0, 7'h7f}, rx);
        chk(16'(rx[15:8]), 16'(e));
    endtask : rd

    task automatic pulse(ref logic s);
        @(negedge clk_sys) s = 1'b1;
        @(negedge clk_sys) s = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask : pulse

    // ----
    // Scenarios
    // ----
    task automatic t_reserved;
        logic [6:0] a [5] = '{ADDR_WAKE_BIAS, ADDR_XCVR_PAIR, ADDR_WAKE_PERIOD,
            ADDR_HW_CONFIG, 7'h09};
        logic [7:0] e [5] = '{8'h03, 8'hdb, 8'h06, 8'hef, 8'h00};
        rd(ADDR_HW_CONFIG, 8'h01);
        foreach (a[i]) begin
            wr(a[i], 8'hfe | 8'(i != 2));
            rd(a[i], e[i]);
        end
    endtask : t_reserved

    task automatic t_fields;
        logic [10:0] ms [7] = '{11'h00a, 11'h014, 11'h032, 11'h064, 11'h0c8,
            11'h3e8, 11'h7d0};
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_WAKE_BIAS, 8'(c));
            for (int p = 0; p < 2; p++) begin
                wake_pin = p[0];
                repeat (6) @(negedge clk_sys);
                chk(16'({ctrl.wake_pull_up, ctrl.wake_pull_down}), 16'((c == 3) ?
                    {p[0], ~p[0]} : c[1:0]));
            end
            wr(ADDR_XCVR_PAIR, {c[0], c[1], 1'b0, c[1:0], 1'b0, ~c[1:0]});
            chk(16'({ctrl.transceiver_two_mode, ctrl.transceiver_one_mode}),
                16'({c[1:0], ~c[1:0]}));
            chk(16'({ctrl.transceiver_two_high_speed,
                ctrl.transceiver_one_high_speed}), 16'({c[0], c[1]}));
            wr(ADDR_HW_CONFIG, {c[0], 3'b000, c[1:0], ~c[1:0]});
            chk(16'({ctrl.adc_sel_battery_sense, ctrl.boost_voltage_select,
                ctrl.external_supply_voltage_select}),
                16'({c[0], c[1:0], ~c[1:0]}));
        end
        for (int c = 0; c < 7; c++) begin
            wr(ADDR_WAKE_PERIOD, 8'(c));
            chk(16'(ctrl.cyclic_period_ms), 16'(ms[c]));
        end
        power_config_pin = 1'b0;
        wr(ADDR_HW_CONFIG, 8'h03);
        chk(16'(ctrl.external_supply_voltage_select), 16'h0001);
        rd(ADDR_HW_CONFIG, 8'h01);
        @(negedge clk_sys) power_config_pin = 1'b1;
        rd(ADDR_HW_CONFIG, 8'h00);
    endtask : t_fields

    task automatic t_events;
        wr(ADDR_WAKE_BIAS, 8'h03);
        wr(ADDR_HW_CONFIG, 8'h2e);
        pulse(soft_rst);
        chk(16'(rst_pin_n), 16'h0000);
        rd(ADDR_HW_CONFIG, 8'h02);
        rd(ADDR_WAKE_BIAS, 8'h00);
        rd(ADDR_WAKE_PERIOD, 8'h00);
        repeat (2600) @(negedge clk_sys);
        chk(16'(rst_pin_n), 16'h0001);
        wr(ADDR_HW_CONFIG, 8'h60);
        batt_low = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk(16'(ctrl.boost_off), 16'h0001);
        pulse(soft_rst);
        chk(16'(rst_pin_n), 16'h0001);
        chk(16'(ctrl.boost_off), 16'h0000);
        batt_low = 1'b0;
        wr(ADDR_WAKE_BIAS, 8'h02);
        wr(ADDR_WAKE_PERIOD, 8'h05);
        wr(ADDR_XCVR_PAIR, 8'hdb);
        pulse(restart);
        rd(ADDR_WAKE_BIAS, 8'h02);
        rd(ADDR_WAKE_PERIOD, 8'h00);
        pulse(fail_safe);
        rd(ADDR_XCVR_PAIR, 8'hc9);
    endtask : t_events

    task automatic wrap_up;
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        {soft_rst, restart, fail_safe, wake_pin, batt_low, resetn} = 6'h01;
        {ce, power_config_pin} = 2'b11;
        @(negedge clk_sys) resetn = 1'b0;
        repeat (3) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (6) @(negedge clk_sys);
        t_reserved;
        t_fields;
        t_events;
        wrap_up;
    end

    initial begin
        #200000;
        n_errors++;
        wrap_up;
    end
endmodule : sbc_wake_bus_hw_control_regs_bench

`default_nettype wire

/* File: tb/spi_host_model.sv */
`default_nettype none

module spi_host_model (
    // Serial link
    output logic o_sck,
    output logic o_csn_n,
    output logic o_mosi,
    input wire logic i_miso
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_sck = 1'b0;
        o_csn_n = 1'b1;
        o_mosi = 1'b0;
    end

    // Whole frame, bit 0 first; clock idles low between frames
    task automatic xfer(input logic [15:0] f, output logic [15:0] r);
        #1.3;
        o_csn_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            o_mosi = f[i];
            #32;
            o_sck = 1'b1;
            r[i] = i_miso;
            #32;
            o_sck = 1'b0;
        end
        #32;
        o_csn_n = 1'b1;
        o_mosi = ~f[15];
        #64;
    endtask : xfer
endmodule : spi_host_model

`default_nettype wire
